// >>> rtl/apoh_device.sv
// Device end: overhead insertion, Add bus driver and AHB-Lite registers
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module apoh_device
  import apoh_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  apoh_if.dev              link,
  input  wire logic [7:0]  lineIn,
  input  wire logic [7:0]  dropLine,
  output logic [7:0]       lineOut,
  input  wire logic [7:0]  lineRx,
  input  wire logic        lineRxValid,
  input  wire logic [3:0]  localRei,
  input  wire logic        localRdi,
  input  wire logic [2:0]  otherClaim,
  output logic             irq
);
  typedef struct packed {
    logic [31:0]            ctrl;
    logic [1:0]             obit;
    logic [7:0]             b3mask;
    logic [2:0]             stat;
    logic [2:0]             imask;
    logic [POH_N-1:0][7:0]  ram;
    logic [POH_N-1:0][7:0]  ohRx;
    logic [15:0]            cnt;
    logic [31:0]            rdata;
    logic                   aWr;
    logic [7:0]             aAddr;
    logic                   irq;
    logic [4:0]             serDiv;
    logic                   serClk;
    logic [6:0]             bitIdx;
    logic [6:0]             ohSh;
    logic                   ohFrame;
    logic                   obCnt;
    logic                   obSh;
    logic [1:0]             obitRx;
    logic [2:0]             rCnt;
    logic [3:0]             rSh;
    logic [3:0]             rei;
    logic                   rdi;
    logic [8:0]             stuck;
    logic [1:0]             slot;
    logic [6:0]             col;
    logic [3:0]             row;
    logic [7:0]             bip;
    logic [7:0]             b3;
    logic [7:0]             ad;
    logic                   slotN;
    logic                   par;
    logic [14:0]            gen;
    logic [14:0]            ana;
    logic [7:0]             lineOut;
  } apoh_dev_t;

  apoh_dev_t s_reg;
  apoh_dev_t s_next;
  logic [10:0] sq;
  logic [10:0] sr;
  logic [10:0] sf;
  logic        qTsel;
  logic        qAclk;
  logic        qAfs;
  logic        qAspe;
  logic        qDclk;
  logic        qDfs;
  logic        qDspe;
  logic        qOhD;
  logic        qObD;
  logic        qRclk;
  logic        qRfr;
  logic        qRd;

  apoh_sync #(.W(11)) u_sync (
    .clock (clock),
    .reset (reset),
    .d     ({link.timingSourceSelect, link.addbusClk, link.addbusFrameStartIn,
             link.addbusPayloadActiveIn, link.dropbusClk, link.dropbusFrameStart,
             link.dropbusPayloadActive, link.txOhPortDataIn, link.txObitDataIn,
             link.ringAlarmFrameIn, link.ringAlarmDataIn}),
    .q     (sq),
    .rise  (sr),
    .fall  (sf)
  );

  apoh_sync #(.W(1)) u_rsync (
    .clock (clock),
    .reset (reset),
    .d     (link.ringAlarmClkIn),
    .q     (),
    .rise  (qRclk),
    .fall  ()
  );

  assign {qTsel, qAclk, qAfs, qAspe, qDclk, qDfs, qDspe, qOhD, qObD, qRfr, qRd} = sq;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic        bt;
    logic        fs;
    logic        spe;
    logic        mine;
    logic        rdHit;
    logic [1:0]  ns;
    logic [6:0]  nc;
    logic [6:0]  pc;
    logic [3:0]  nr;
    logic [7:0]  pay;
    logic [7:0]  d;
    logic [14:0] gn;
    logic [14:0] ga;
    logic [2:0]  setS;
    logic [3:0]  ri;
    logic [3:0]  wi;
    logic [15:0] cb;
    logic [31:0] rd;
    bt = qTsel ? sr[9] : sr[6];
    fs = qTsel ? qAfs : qDfs;
    spe = qTsel ? qAspe : qDspe;
    ns = s_reg.slot;
    nc = s_reg.col;
    nr = s_reg.row;
    mine = 1'b0;
    pc = s_reg.ctrl[C_TUG3] ? POH_TUG : POH_STS;
    gn = prbsStep(s_reg.gen);
    ga = prbsStep(s_reg.ana);
    pay = s_reg.ctrl[C_FLB] ? dropLine : lineIn;
    d = 8'h00;
    setS = 3'b000;
    rdHit = 1'b0;
    ri = 4'(haddr[7:0] - A_RAM >> 2);
    wi = 4'(s_reg.aAddr - A_RAM >> 2);
    rd = 32'h0000_0000;
    s_next = s_reg;
    if (s_reg.ctrl[C_PGEN])
      pay = gn[7:0];
    // Byte position on the selected bus timing
    if (fs)
    begin
      ns = 2'd0;
      nc = 7'd0;
      nr = 4'd0;
    end
    else if (s_reg.slot == SLOT_LAST)
    begin
      ns = 2'd0;
      nc = (s_reg.col == COL_LAST) ? 7'd0 : s_reg.col + 7'd1;
      if (s_reg.col == COL_LAST)
        nr = (s_reg.row == ROW_LAST) ? 4'd0 : s_reg.row + 4'd1;
    end
    else
      ns = s_reg.slot + 2'd1;
    mine = spe && ns == s_reg.ctrl[C_SLOT+:2];
    if (s_reg.ctrl[C_TUG3] && nc == POH_STS)
      d = (nr == 4'd0) ? TUG3_PTR[15:8] : (nr == 4'd1) ? TUG3_PTR[7:0] : 8'h00;
    else if (nc == pc && nr == ROW_B3)
      d = s_reg.b3 ^ s_reg.b3mask;
    else if (nc == pc && nr == ROW_G1)
    begin
      unique case (apoh_g1src_t'(s_reg.ctrl[C_G1S+:2]))
        G1_RAM:   d = s_reg.ram[ROW_G1];
        G1_PORT:  d = s_reg.ohRx[ROW_G1];
        G1_LOCAL: d = {localRei, localRdi, 3'b000};
        G1_RING:  d = {s_reg.rei, s_reg.rdi, 3'b000};
      endcase
    end
    else if (nc == pc)
      d = s_reg.ctrl[C_OHS + int'(nr)] ? s_reg.ohRx[nr] : s_reg.ram[nr];
    else if (nc == pc + 7'd1 && nr == 4'd0)
      d = {pay[7:2], s_reg.ctrl[C_OBIT] ? s_reg.obitRx : s_reg.obit};
    else
      d = pay;
    if (bt)
    begin
      s_next.slot = ns;
      s_next.col = nc;
      s_next.row = nr;
      s_next.ad = d;
      s_next.slotN = !mine;
      s_next.par = ~^d;
      s_next.bip = (fs ? 8'h00 : s_reg.bip) ^ (mine ? d : 8'h00);
      if (fs)
        s_next.b3 = s_reg.bip;
      if (mine && s_reg.ctrl[C_PGEN])
        s_next.gen = gn;
      if (mine && otherClaim[s_reg.ctrl[C_SLOT+:2]])
        setS[S_CONT] = 1'b1;
    end
    // Stuck Add bus clock watch
    if (sr[9] || sf[9])
      s_next.stuck = 9'd0;
    else if (s_reg.stuck != STUCK_CYC)
      s_next.stuck = s_reg.stuck + 9'd1;
    if (qTsel && s_reg.stuck == STUCK_CYC)
      setS[S_STUCK] = 1'b1;
    // Serial overhead and O-bit ports on one divided clock
    s_next.serDiv = (s_reg.serDiv == SER_DIV - 5'd1) ? 5'd0 : s_reg.serDiv + 5'd1;
    if (s_reg.serDiv == SER_DIV - 5'd1)
    begin
      s_next.serClk = ~s_reg.serClk;
      if (!s_reg.serClk)
      begin
        s_next.ohSh = {s_reg.ohSh[5:0], qOhD};
        if (s_reg.bitIdx[2:0] == 3'd7)
          s_next.ohRx[s_reg.bitIdx[6:3]] = {s_reg.ohSh, qOhD};
        s_next.bitIdx = (s_reg.bitIdx == OH_LAST) ? 7'd0 : s_reg.bitIdx + 7'd1;
        s_next.ohFrame = s_reg.bitIdx == OH_LAST;
        s_next.obCnt = ~s_reg.obCnt;
        s_next.obSh = qObD;
        if (s_reg.obCnt)
          s_next.obitRx = {s_reg.obSh, qObD};
      end
    end
    // Ring alarm port
    if (qRclk)
    begin
      if (qRfr)
      begin
        s_next.rCnt = 3'd1;
        s_next.rSh = {3'b000, qRd};
      end
      else if (s_reg.rCnt < RING_BITS - 3'd1)
      begin
        s_next.rCnt = s_reg.rCnt + 3'd1;
        s_next.rSh = {s_reg.rSh[2:0], qRd};
      end
      else if (s_reg.rCnt == RING_BITS - 3'd1)
      begin
        s_next.rCnt = RING_BITS;
        s_next.rei = s_reg.rSh;
        s_next.rdi = qRd;
      end
    end
    // Copy sent port bytes into RAM
    if (bt && mine && s_reg.ctrl[C_COPY] && nc == pc && nr != ROW_B3
        && s_reg.ctrl[C_OHS + int'(nr)])
      s_next.ram[nr] = s_reg.ohRx[nr];
    // ****************************************
    // AHB-Lite slave
    // ****************************************
    if (hsel && htrans[1] && hready)
    begin
      s_next.aWr = hwrite;
      s_next.aAddr = haddr[7:0];
      unique case (haddr[7:0])
        A_CTRL: rd = s_reg.ctrl;
        A_OBIT: rd = {30'h0, s_reg.obitRx};
        A_MASK: rd = {24'h0, s_reg.b3mask};
        A_STAT: rd = {29'h0, s_reg.stat};
        A_IMSK: rd = {29'h0, s_reg.imask};
        A_RING: rd = {27'h0, s_reg.rei, s_reg.rdi};
        A_CNT:  rd = {16'h0, s_reg.cnt};
        default:
          if (haddr[7:0] >= A_RAM && haddr[7:0] < A_RAM_END)
            rd = {24'h0, s_reg.ram[ri]};
      endcase
      s_next.rdata = rd;
      rdHit = !hwrite && haddr[7:0] == A_CNT;
    end
    else
      s_next.aWr = 1'b0;
    if (s_reg.aWr)
    begin
      unique case (s_reg.aAddr)
        A_CTRL: s_next.ctrl = hwdata;
        A_OBIT: s_next.obit = hwdata[1:0];
        A_MASK: s_next.b3mask = hwdata[7:0];
        A_STAT: s_next.stat = s_reg.stat & ~hwdata[2:0];
        A_IMSK: s_next.imask = hwdata[2:0];
        default:
          if (s_reg.aAddr >= A_RAM && s_reg.aAddr < A_RAM_END)
            s_next.ram[wi] = hwdata[7:0];
      endcase
    end
    // PRBS analyzer and its error counter
    cb = (rdHit && s_reg.ctrl[C_SAT]) ? 16'h0000 : s_reg.cnt;
    s_next.cnt = cb;
    if (lineRxValid)
    begin
      s_next.ana = ga;
      if (lineRx != ga[7:0])
      begin
        setS[S_PRBS] = 1'b1;
        if (!(s_reg.ctrl[C_SAT] && cb == 16'hFFFF))
          s_next.cnt = cb + 16'h0001;
      end
    end
    s_next.stat = s_next.stat | setS;
    s_next.irq = |(s_reg.stat & s_reg.imask);
    s_next.lineOut = s_reg.ctrl[C_LLB] ? lineIn : dropLine;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.serClk <= 1'b1;
      s_reg.ohFrame <= 1'b1;
      s_reg.slotN <= 1'b1;
      s_reg.par <= 1'b1;
      s_reg.gen <= PRBS_SEED;
      s_reg.ana <= PRBS_SEED;
    end
    else
      s_reg <= s_next;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign lineOut = s_reg.lineOut;
  assign link.addbusData = s_reg.ad;
  assign link.addbusSlotN = s_reg.slotN;
  assign link.addbusOddParity = s_reg.par;
  assign link.outEn = !s_reg.ctrl[C_HIZ];
  assign link.txOhPortClkOut = s_reg.serClk;
  assign link.txOhPortFramePulse = s_reg.ohFrame;
  assign link.txObitClkOut = s_reg.serClk;
endmodule

// >>> inc/apoh_pkg.sv
// Constants, register map and helpers for the add-side overhead insert link
package apoh_pkg;
  localparam int CLK_MHZ  = 250;
  localparam int STUCK_NS = 1000;
  localparam logic [8:0] STUCK_CYC = 9'(STUCK_NS * CLK_MHZ / 1000);
  localparam logic [4:0] SER_DIV = 5'd16;
  localparam logic [2:0] ADD_DIV = 3'd6;
  localparam logic [1:0] SLOT_LAST = 2'd2;
  localparam logic [6:0] COL_LAST = 7'd89;
  localparam logic [3:0] ROW_LAST = 4'd8;
  localparam logic [6:0] POH_STS = 7'd3;
  localparam logic [6:0] POH_TUG = 7'd4;
  localparam logic [3:0] ROW_B3 = 4'd1;
  localparam logic [3:0] ROW_G1 = 4'd3;
  localparam int POH_N = 9;
  localparam logic [6:0] OH_LAST = 7'd71;
  localparam logic [2:0] RING_BITS = 3'd5;
  localparam logic [15:0] TUG3_PTR = 16'h6800;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OBIT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_IMSK = 8'h10;
  localparam logic [7:0] A_RING = 8'h14;
  localparam logic [7:0] A_CNT  = 8'h18;
  localparam logic [7:0] A_RAM  = 8'h20;
  localparam logic [7:0] A_RAM_END = 8'h44;
  localparam int C_OBIT = 0;
  localparam int C_COPY = 1;
  localparam int C_G1S  = 2;
  localparam int C_TUG3 = 4;
  localparam int C_SAT  = 5;
  localparam int C_HIZ  = 6;
  localparam int C_LLB  = 7;
  localparam int C_FLB  = 8;
  localparam int C_PGEN = 9;
  localparam int C_SLOT = 10;
  localparam int C_OHS  = 16;
  localparam int S_STUCK = 0;
  localparam int S_CONT  = 1;
  localparam int S_PRBS  = 2;

  typedef enum logic [1:0] {
    G1_RAM   = 2'b00,
    G1_PORT  = 2'b01,
    G1_LOCAL = 2'b10,
    G1_RING  = 2'b11
  } apoh_g1src_t;

  // Eight steps of x^15 + x^14 + 1
  function automatic logic [14:0] prbsStep(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 8; i++)
      t = {t[13:0], t[14] ^ t[13]};
    return t;
  endfunction
endpackage

// >>> inc/apoh_if.sv
// Link between the overhead insert device and the Add bus framer side
`timescale 1ns/100ps
interface apoh_if;
  logic       timingSourceSelect;
  logic       addbusClk;
  logic       addbusFrameStartIn;
  logic       addbusPayloadActiveIn;
  logic       dropbusClk;
  logic       dropbusFrameStart;
  logic       dropbusPayloadActive;
  logic [7:0] addbusData;
  logic       addbusSlotN;
  logic       addbusOddParity;
  logic       outEn;
  logic       txOhPortClkOut;
  logic       txOhPortFramePulse;
  logic       txOhPortDataIn;
  logic       txObitClkOut;
  logic       txObitDataIn;
  logic       ringAlarmClkIn;
  logic       ringAlarmFrameIn;
  logic       ringAlarmDataIn;

  modport dev (
    input  timingSourceSelect, addbusClk, addbusFrameStartIn, addbusPayloadActiveIn,
    input  dropbusClk, dropbusFrameStart, dropbusPayloadActive,
    output addbusData, addbusSlotN, addbusOddParity, outEn,
    output txOhPortClkOut, txOhPortFramePulse, txObitClkOut,
    input  txOhPortDataIn, txObitDataIn,
    input  ringAlarmClkIn, ringAlarmFrameIn, ringAlarmDataIn
  );

  modport far (
    output timingSourceSelect, addbusClk, addbusFrameStartIn, addbusPayloadActiveIn,
    output dropbusClk, dropbusFrameStart, dropbusPayloadActive,
    input  addbusData, addbusSlotN, addbusOddParity, outEn,
    input  txOhPortClkOut, txOhPortFramePulse, txObitClkOut,
    output txOhPortDataIn, txObitDataIn,
    output ringAlarmClkIn, ringAlarmFrameIn, ringAlarmDataIn
  );
endinterface

// >>> rtl/apoh_sync.sv
// Two-stage synchroniser with edge detect on the settled level
`timescale 1ns/100ps
module apoh_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } apoh_sync_t;

  apoh_sync_t s_reg;
  apoh_sync_t s_next;

  always_comb
  begin
    s_next.meta = d;
    s_next.lvl  = s_reg.meta;
    s_next.prev = s_reg.lvl;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q    = s_reg.lvl;
  assign rise = s_reg.lvl & ~s_reg.prev;
  assign fall = ~s_reg.lvl & s_reg.prev;
endmodule

// >>> rtl/apoh_framer_end.sv
// Far end: Add bus timing source, serial overhead sources, ring mate, Add bus sink
`timescale 1ns/100ps
module apoh_framer_end
  import apoh_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  apoh_if.far              link,
  input  wire logic        timingSel,
  input  wire logic [71:0] ohTx,
  input  wire logic [1:0]  obitTx,
  input  wire logic [3:0]  ringRei,
  input  wire logic        ringRdi,
  output logic [7:0]       rxByte,
  output logic             rxValid,
  output logic             rxParityErr
);
  typedef struct packed {
    logic       tsel;
    logic [2:0] div;
    logic       aclk;
    logic [1:0] slot;
    logic [6:0] col;
    logic [3:0] row;
    logic       fs;
    logic       spe;
    logic [4:0] rdiv;
    logic       rclk;
    logic [2:0] ridx;
    logic       rframe;
    logic       rdata;
    logic [6:0] ohIdx;
    logic       ohD;
    logic       obT;
    logic       obD;
    logic [7:0] rxByte;
    logic       rxValid;
    logic       rxPerr;
  } apoh_far_t;

  apoh_far_t  s_reg;
  apoh_far_t  s_next;
  logic [13:0] q;
  logic [13:0] f;
  logic       qSlotN;
  logic       qPar;
  logic [7:0] qData;
  logic       qOhClk;
  logic       qOhFr;
  logic       qObClk;
  logic       qOe;

  apoh_sync #(.W(14)) u_sync (
    .clock (clock),
    .reset (reset),
    .d     ({link.addbusSlotN, link.addbusOddParity, link.addbusData,
             link.txOhPortClkOut, link.txOhPortFramePulse, link.txObitClkOut, link.outEn}),
    .q     (q),
    .rise  (),
    .fall  (f)
  );

  assign {qSlotN, qPar, qData, qOhClk, qOhFr, qObClk, qOe} = q;

  always_comb
  begin
    logic [4:0] rv;
    logic [6:0] idx;
    rv = {ringRei, ringRdi};
    idx = qOhFr ? 7'd0 : s_reg.ohIdx;
    s_next = s_reg;
    s_next.tsel = timingSel;
    s_next.rxValid = 1'b0;
    // Add bus byte clock and position
    s_next.div = (s_reg.div == ADD_DIV - 3'd1) ? 3'd0 : s_reg.div + 3'd1;
    if (s_reg.div == ADD_DIV - 3'd1)
    begin
      s_next.aclk = ~s_reg.aclk;
      if (!s_reg.aclk)
      begin
        s_next.slot = (s_reg.slot == SLOT_LAST) ? 2'd0 : s_reg.slot + 2'd1;
        if (s_reg.slot == SLOT_LAST)
        begin
          s_next.col = (s_reg.col == COL_LAST) ? 7'd0 : s_reg.col + 7'd1;
          if (s_reg.col == COL_LAST)
            s_next.row = (s_reg.row == ROW_LAST) ? 4'd0 : s_reg.row + 4'd1;
        end
        s_next.fs = s_reg.slot == SLOT_LAST && s_reg.col == COL_LAST
                    && s_reg.row == ROW_LAST;
        s_next.spe = s_next.col >= POH_STS;
        // Byte sent for the previous slot
        s_next.rxByte = qData;
        s_next.rxValid = qOe && !qSlotN;
        s_next.rxPerr = qOe && !qSlotN && !(^{qData, qPar});
      end
    end
    // Overhead port source, driven on the falling clock
    if (f[3])
    begin
      s_next.ohD = ohTx[OH_LAST - idx];
      s_next.ohIdx = idx + 7'd1;
    end
    if (f[1])
    begin
      s_next.obD = s_reg.obT ? obitTx[0] : obitTx[1];
      s_next.obT = ~s_reg.obT;
    end
    // Ring mate alarm port
    s_next.rdiv = (s_reg.rdiv == SER_DIV - 5'd1) ? 5'd0 : s_reg.rdiv + 5'd1;
    if (s_reg.rdiv == SER_DIV - 5'd1)
    begin
      s_next.rclk = ~s_reg.rclk;
      if (!s_reg.rclk)
      begin
        s_next.ridx = s_reg.ridx + 3'd1;
        s_next.rframe = s_reg.ridx == 3'd0;
        s_next.rdata = (s_reg.ridx < RING_BITS) ? rv[3'd4 - s_reg.ridx] : 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.slot <= SLOT_LAST;
      s_reg.col <= COL_LAST;
      s_reg.row <= ROW_LAST;
    end
    else
      s_reg <= s_next;
  end

  assign link.timingSourceSelect = s_reg.tsel;
  assign link.addbusClk = s_reg.aclk;
  assign link.addbusFrameStartIn = s_reg.fs;
  assign link.addbusPayloadActiveIn = s_reg.spe;
  assign link.dropbusClk = s_reg.aclk;
  assign link.dropbusFrameStart = s_reg.fs;
  assign link.dropbusPayloadActive = s_reg.spe;
  assign link.txOhPortDataIn = s_reg.ohD;
  assign link.txObitDataIn = s_reg.obD;
  assign link.ringAlarmClkIn = s_reg.rclk;
  assign link.ringAlarmFrameIn = s_reg.rframe;
  assign link.ringAlarmDataIn = s_reg.rdata;
  assign rxByte = s_reg.rxByte;
  assign rxValid = s_reg.rxValid;
  assign rxParityErr = s_reg.rxPerr;
endmodule

// >>> sim/apoh_link_monitor.sv
// Concurrent checks on the add side overhead link signals
`timescale 1ns/100ps
module apoh_link_monitor (
  input logic       clock,
  input logic       reset,
  input logic       addbusClk,
  input logic       addbusFrameStartIn,
  input logic       addbusPayloadActiveIn,
  input logic [7:0] addbusData,
  input logic       addbusSlotN,
  input logic       addbusOddParity,
  input logic       txOhPortClkOut,
  input logic       txOhPortFramePulse,
  input logic       txObitClkOut,
  input logic       ringAlarmClkIn
);
  logic [3:0] sinceRise_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Cycles since the last bus clock rise
  always_ff @(posedge clock)
  begin
    if (reset)
      sinceRise_reg <= 4'h0;
    else if ($rose(addbusClk))
      sinceRise_reg <= 4'h1;
    else if (sinceRise_reg != 4'hF)
      sinceRise_reg <= sinceRise_reg + 4'h1;
  end

  sequence busRise;
    $rose(addbusClk);
  endsequence

  parity_odd_a:
    assert property (^{addbusData, addbusOddParity})
    else $error("Add bus parity is even");
  data_timing_a:
    assert property ($changed(addbusData) |-> sinceRise_reg inside {[4'h3:4'h5]})
    else $error("Add bus data moved off its clock step");
  slot_flag_a:
    assert property ($fell(addbusSlotN) |-> $past(addbusPayloadActiveIn, 3))
    else $error("Slot flag low outside payload");
  add_clock_a:
    assert property (busRise |-> ##12 busRise)
    else $error("Add bus clock period wrong");
  start_align_a:
    assert property ($changed(addbusFrameStartIn) |-> busRise)
    else $error("Frame start moved off the clock rise");
  oh_clock_a:
    assert property ($fell(txOhPortClkOut) |-> ##16 $rose(txOhPortClkOut))
    else $error("Overhead port clock half period wrong");
  obit_clock_a:
    assert property (txObitClkOut == txOhPortClkOut)
    else $error("O-bit clock differs from port clock");
  frame_pulse_a:
    assert property ($changed(txOhPortFramePulse) |-> $rose(txOhPortClkOut))
    else $error("Frame pulse moved off the port clock rise");
  ring_clock_a:
    assert property ($rose(ringAlarmClkIn) |-> ##32 $rose(ringAlarmClkIn))
    else $error("Ring clock period wrong");
endmodule

// >>> sim/add_side_poh_insert_bus_tb.sv
// Self-checking bench for the add side overhead insert link
`timescale 1ns/100ps
module add_side_poh_insert_bus_tb
  import apoh_pkg::*;
;
  logic        clock, reset, hsel, hwrite, hreadyout, hresp, irq;
  logic        timingSel, ringRdi, rxValid, rxParityErr, found;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, obitTx;
  logic [2:0]  hsize, otherClaim;
  logic [7:0]  lineIn, dropLine, lineOut, rxByte;
  logic [71:0] ohTx;
  logic [3:0]  ringRei;
  int          errors, comparisons;

  apoh_if link ();

  apoh_device u_apoh_device (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link.dev), .lineIn(lineIn), .dropLine(dropLine),
    .lineOut(lineOut), .lineRx(8'h00), .lineRxValid(1'h0),
    .localRei(4'h0), .localRdi(1'h0), .otherClaim(otherClaim), .irq(irq)
  );

  apoh_framer_end u_apoh_framer_end (
    .clock(clock), .reset(reset), .link(link.far), .timingSel(timingSel),
    .ohTx(ohTx), .obitTx(obitTx), .ringRei(ringRei), .ringRdi(ringRdi),
    .rxByte(rxByte), .rxValid(rxValid), .rxParityErr(rxParityErr)
  );

  apoh_link_monitor u_apoh_link_monitor (
    .clock(clock), .reset(reset), .addbusClk(link.addbusClk),
    .addbusFrameStartIn(link.addbusFrameStartIn),
    .addbusPayloadActiveIn(link.addbusPayloadActiveIn),
    .addbusData(link.addbusData), .addbusSlotN(link.addbusSlotN),
    .addbusOddParity(link.addbusOddParity),
    .txOhPortClkOut(link.txOhPortClkOut),
    .txOhPortFramePulse(link.txOhPortFramePulse),
    .txObitClkOut(link.txObitClkOut), .ringAlarmClkIn(link.ringAlarmClkIn)
  );

  // ****
  // Bus and check tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'h0, a, 32'h0);
    chk(hrdata, exp);
  endtask

  task automatic waitRx(input logic [7:0] v);
    found = 1'h0;
    for (int i = 0; i < 40000 && !found; i++)
    begin
      @(posedge clock);
      found = (rxValid === 1'h1) && (rxByte === v);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****
  // Clock, watchdog and tests
  // ****
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    repeat (90000) @(posedge clock);
    errors++;
    conclude();
  end

  always @(posedge clock)
    if (rxValid === 1'h1)
      chk(32'(rxParityErr), 32'h0);

  initial
  begin
    {reset, timingSel, ringRdi} = 3'h7;
    {hsel, hwrite, htrans, haddr, hwdata, otherClaim} = '0;
    hsize = 3'h2;
    ohTx = {8'h5A, 64'h0};
    obitTx = 2'h2;
    ringRei = 4'hA;
    lineIn = 8'h11;
    dropLine = 8'h22;
    {errors, comparisons} = '0;
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    rd(A_CTRL, 32'h0);
    acc(1'h1, A_MASK, 32'h1A5);
    rd(A_MASK, 32'hA5);
    rd(8'hFC, 32'h0);
    acc(1'h1, A_RAM + 8'h8, 32'h3C);
    rd(A_RAM + 8'h8, 32'h3C);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'h1, A_CTRL, 32'(i) << 2);
      rd(A_CTRL, 32'(i) << 2);
    end
    acc(1'h1, A_CTRL, 32'hA0);
    rd(A_CTRL, 32'hA0);
    chk(32'(lineOut), 32'h11);
    acc(1'h1, A_CTRL, 32'h40);
    rd(A_CTRL, 32'h40);
    chk(32'(lineOut), 32'h22);
    chk(32'(link.outEn), 32'h0);
    acc(1'h1, A_CTRL, 32'h10003);
    repeat (6000) @(posedge clock);
    rd(A_OBIT, 32'h2);
    rd(A_RING, 32'h15);
    waitRx(8'h5A);
    chk(32'(found), 32'h1);
    rd(A_RAM, 32'h5A);
    acc(1'h1, A_IMSK, 32'h2);
    otherClaim <= 3'h1;
    repeat (1000) @(posedge clock);
    rd(A_STAT, 32'h2);
    chk(32'(irq), 32'h1);
    otherClaim <= 3'h0;
    acc(1'h1, A_STAT, 32'h2);
    rd(A_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    timingSel <= 1'h0;
    waitRx(8'h5A);
    chk(32'(found), 32'h1);
    conclude();
  end
endmodule
